// ### inc/rsc_cfg.svh
// Purpose: constants of the radio sleep controller and its host end
// Assumes: 200 MHz ref_clk_i
// Notes:   times are in 100 ms units unless named otherwise
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ==========================================================
// timing
`define RSC_CLK_MHZ        200
`define RSC_UNIT_MS        100
`define RSC_TICK_W         25
`define RSC_LISTEN_UNITS   15'h0001
`define RSC_CYC_BASE_UNITS 15'h000a

// ==========================================================
// sleep modes and parameter values
`define RSC_MODE_OFF       4'h0
`define RSC_MODE_PIN       4'h1
`define RSC_MODE_SER       4'h2
`define RSC_MODE_RSV       4'h3
`define RSC_MODE_CYC_FIRST 4'h4
`define RSC_MODE_CYC_LAST  4'h8
`define RSC_INACT_RST      15'h0064
`define RSC_INACT_MAX      16'h7fff

// ==========================================================
// binary command codes
`define RSC_CMD_MODE       8'h01
`define RSC_CMD_INACT      8'h02
`define RSC_CMD_TEMP       8'h38
`define RSC_CMD_FAIL       8'h1b
`define RSC_CMD_SNLO       8'h26
`define RSC_CMD_PWAKE      8'h1d

// ==========================================================
// host register map and fields
`define RSC_A_CTRL         8'h00
`define RSC_A_CMD          8'h04
`define RSC_A_STATUS       8'h08
`define RSC_A_IRQ_STAT     8'h0c
`define RSC_A_IRQ_CLR      8'h10
`define RSC_A_IRQ_EN       8'h14
`define RSC_A_SERIAL       8'h18
`define RSC_CMD_WR_BIT     8
`define RSC_CMD_DATA_LSB   16
`define RSC_IRQ_RSP        0
`define RSC_IRQ_CTS        1
`define RSC_IRQ_PWR        2
`define RSC_IRQ_W          3

`endif

// ### inc/rsc_pkg.sv
// Purpose: types of the radio sleep controller
// Assumes: rsc_cfg.svh constants
// Notes:   whole module state lives in one packed struct
`include "rsc_cfg.svh"

package rsc_pkg;

  // ==========================================================
  // device power states
  typedef enum logic [2:0] {
    RSC_AWAKE,
    RSC_PIN_SLP,
    RSC_SER_SLP,
    RSC_CYC_SLP,
    RSC_LISTEN,
    RSC_SYNC
  } rsc_state_t;

  // ==========================================================
  // device state
  typedef struct packed {
    rsc_state_t                 st;
    logic [3:0]                 mode;
    logic [14:0]                inact;
    logic                       pwake;
    logic [`RSC_TICK_W-1:0]     tick_cnt;
    logic                       tick;
    logic [14:0]                units;
    logic [15:0]                fail_cnt;
    logic [6:0]                 temp;
    logic                       sleep_q;
    logic                       flow_hold;
    logic                       power;
    logic                       payload_en;
    logic                       rsp_valid;
    logic [15:0]                rsp_data;
    logic                       tx_valid;
    logic [7:0]                 tx_data;
  } rsc_dev_t;

  // ==========================================================
  // host state
  typedef struct packed {
    logic                       pready;
    logic [31:0]                prdata;
    logic                       sleep_req;
    logic                       cmd_valid;
    logic                       cmd_write;
    logic [7:0]                 cmd_code;
    logic [15:0]                cmd_wdata;
    logic                       busy;
    logic [15:0]                rsp_data;
    logic                       ser_pend;
    logic [7:0]                 ser_byte;
    logic                       ser_valid;
    logic [7:0]                 ser_data;
    logic [`RSC_IRQ_W-1:0]      irq_stat;
    logic [`RSC_IRQ_W-1:0]      irq_en;
    logic                       irq;
    logic                       cts_q;
    logic                       pwr_q;
  } rsc_host_t;

endpackage

// ### inc/rsc_link_if.sv
// Purpose: pins between host controller and radio sleep controller
// Assumes: both ends on ref_clk_i, signals synchronous to it
// Notes:   flow_hold_output high means do not send
interface rsc_link_if;
  logic        sleep_request_input;
  logic        serial_data_valid;
  logic [7:0]  serial_data_input;
  logic        cmd_valid;
  logic        cmd_write;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wdata;
  logic        flow_hold_output;
  logic        power_indicator_output;
  logic        rsp_valid;
  logic [15:0] rsp_data;

  modport dev (
    input  sleep_request_input, serial_data_valid, serial_data_input,
    input  cmd_valid, cmd_write, cmd_code, cmd_wdata,
    output flow_hold_output, power_indicator_output, rsp_valid, rsp_data
  );

  modport host (
    output sleep_request_input, serial_data_valid, serial_data_input,
    output cmd_valid, cmd_write, cmd_code, cmd_wdata,
    input  flow_hold_output, power_indicator_output, rsp_valid, rsp_data
  );
endinterface

// ### hw/rsc_dev.sv
// Purpose: sleep controller of the radio module (device end)
// Assumes: link and rf inputs synchronous to ref_clk_i
// Notes:   inactivity and sleep intervals resolve to one 100 ms unit
//
// Contract
// - mode 0 off,1 pin,2 serial,4-8 cyclic
// - pin mode sleeps while sleep input high
// - pin sleep: hold flow, power indicator low
// - serial sleep after inactivity, character wakes
// - cyclic sleep after radio inactivity period
// - wake per interval, listen window, resleep
// - payload only after wake initializer ends
// - cyclic sleep holds flow, listening releases
// - pin wake forces idle until inactive
// - host keeps interval below initializer length
// - inactivity in 100 ms units, reset 100
// - temperature read-only byte up to 0x7f
// - count packets dropped after retries
// - failure counter clears on every reset
// - serial number low word read-only
// - command codes select the parameters
`include "rsc_cfg.svh"

module rsc_dev #(
  parameter int unsigned TICK_CYCLES = `RSC_UNIT_MS * 1000 * `RSC_CLK_MHZ
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  rsc_link_if.dev          link,
  input  wire logic        rf_activity_i,
  input  wire logic        wake_init_detect_i,
  input  wire logic        wake_init_done_i,
  input  wire logic        tx_fail_i,
  input  wire logic [6:0]  temperature_i,
  input  wire logic [15:0] serial_number_low_word_i,
  output logic             payload_enable_o,
  output logic             rf_tx_valid_o,
  output logic [7:0]       rf_tx_data_o
);
  import rsc_pkg::*;

  rsc_dev_t s_r;
  rsc_dev_t s_nxt;

  logic        pin_fall;
  logic        cyclic;
  logic        serial_act;
  logic        activity;
  logic        mode_chg;
  logic [14:0] cyc_units;

  // ==========================================================
  // next state
  always_comb begin
    s_nxt          = s_r;
    s_nxt.tick     = 1'b0;
    s_nxt.rsp_valid = 1'b0;
    s_nxt.tx_valid = 1'b0;
    mode_chg       = 1'b0;
    cyclic     = (s_r.mode >= `RSC_MODE_CYC_FIRST) &&
                 (s_r.mode <= `RSC_MODE_CYC_LAST);
    cyc_units  = `RSC_CYC_BASE_UNITS << (s_r.mode - `RSC_MODE_CYC_FIRST);
    pin_fall   = s_r.sleep_q & ~link.sleep_request_input;
    serial_act = link.serial_data_valid;
    // cyclic modes watch the radio only; serial mode watches both directions
    activity   = cyclic ? rf_activity_i : (serial_act | rf_activity_i);

    // unit divider
    if (s_r.tick_cnt == `RSC_TICK_W'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick     = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + `RSC_TICK_W'(1);
    end

    s_nxt.temp    = temperature_i;
    s_nxt.sleep_q = link.sleep_request_input;
    // saturates instead of wrapping to zero
    if (tx_fail_i && (s_r.fail_cnt != 16'hffff)) begin
      s_nxt.fail_cnt = s_r.fail_cnt + 16'h0001;
    end

    // characters are forwarded in every state except pin sleep and cyclic sleep
    if (serial_act && (s_r.st != RSC_PIN_SLP) && (s_r.st != RSC_CYC_SLP)) begin
      s_nxt.tx_valid = 1'b1;
      s_nxt.tx_data  = link.serial_data_input;
    end

    // ==========================================================
    // command decode
    if (link.cmd_valid && link.cmd_write) begin
      unique case (link.cmd_code)
        `RSC_CMD_MODE: begin
          // reserved and out-of-range values are refused
          if ((link.cmd_wdata <= 16'(`RSC_MODE_CYC_LAST)) &&
              (link.cmd_wdata != 16'(`RSC_MODE_RSV))) begin
            s_nxt.mode = link.cmd_wdata[3:0];
            mode_chg   = 1'b1;
          end
        end
        `RSC_CMD_INACT: begin
          if (link.cmd_wdata <= `RSC_INACT_MAX) begin
            s_nxt.inact = link.cmd_wdata[14:0];
          end
        end
        `RSC_CMD_PWAKE: begin
          s_nxt.pwake = link.cmd_wdata[0];
        end
        default: begin
        end
      endcase
    end
    if (link.cmd_valid) begin
      s_nxt.rsp_valid = 1'b1;
      unique case (link.cmd_code)
        `RSC_CMD_MODE:  s_nxt.rsp_data = {12'h000, s_nxt.mode};
        `RSC_CMD_INACT: s_nxt.rsp_data = {1'b0, s_nxt.inact};
        `RSC_CMD_TEMP:  s_nxt.rsp_data = {9'h000, s_r.temp};
        `RSC_CMD_FAIL:  s_nxt.rsp_data = s_r.fail_cnt;
        `RSC_CMD_SNLO:  s_nxt.rsp_data = serial_number_low_word_i;
        `RSC_CMD_PWAKE: s_nxt.rsp_data = {15'h0000, s_nxt.pwake};
        default:        s_nxt.rsp_data = 16'h0000;
      endcase
    end

    // ==========================================================
    // power state machine
    if (mode_chg) begin
      // a new mode always restarts from idle
      s_nxt.st    = RSC_AWAKE;
      s_nxt.units = '0;
    end else begin
      unique case (s_r.st)
        RSC_AWAKE: begin
          if (s_r.mode == `RSC_MODE_PIN) begin
            if (link.sleep_request_input) begin
              s_nxt.st = RSC_PIN_SLP;
            end
          end else if ((s_r.mode == `RSC_MODE_SER) || cyclic) begin
            if (activity) begin
              s_nxt.units = '0;
            end else if (s_r.tick) begin
              if ((s_r.units + 15'h0001) >= s_r.inact) begin
                s_nxt.units = '0;
                s_nxt.st    = cyclic ? RSC_CYC_SLP : RSC_SER_SLP;
              end else begin
                s_nxt.units = s_r.units + 15'h0001;
              end
            end
          end
          // modes 0 and 3 fall through and stay awake
        end
        RSC_PIN_SLP: begin
          if (!link.sleep_request_input) begin
            s_nxt.st = RSC_AWAKE;
          end
        end
        RSC_SER_SLP: begin
          if (serial_act) begin
            s_nxt.st    = RSC_AWAKE;
            s_nxt.units = '0;
          end
        end
        RSC_CYC_SLP: begin
          if (s_r.pwake && pin_fall) begin
            s_nxt.st    = RSC_AWAKE;
            s_nxt.units = '0;
          end else if (s_r.tick) begin
            if ((s_r.units + 15'h0001) >= cyc_units) begin
              s_nxt.st    = RSC_LISTEN;
              s_nxt.units = '0;
            end else begin
              s_nxt.units = s_r.units + 15'h0001;
            end
          end
        end
        RSC_LISTEN: begin
          if (s_r.pwake && pin_fall) begin
            s_nxt.st    = RSC_AWAKE;
            s_nxt.units = '0;
          end else if (wake_init_detect_i) begin
            s_nxt.st    = RSC_SYNC;
            s_nxt.units = '0;
          end else if (s_r.tick) begin
            if ((s_r.units + 15'h0001) >= `RSC_LISTEN_UNITS) begin
              s_nxt.st    = RSC_CYC_SLP;
              s_nxt.units = '0;
            end else begin
              s_nxt.units = s_r.units + 15'h0001;
            end
          end
        end
        RSC_SYNC: begin
          // initializer length is the sender's business
          if (wake_init_done_i) begin
            s_nxt.st    = RSC_AWAKE;
            s_nxt.units = '0;
          end
        end
        default: begin
          s_nxt.st = RSC_AWAKE;
        end
      endcase
    end

    // ==========================================================
    // pin levels follow the next state so they change with it
    s_nxt.flow_hold  = (s_nxt.st == RSC_PIN_SLP) || (s_nxt.st == RSC_CYC_SLP);
    s_nxt.power      = !((s_nxt.st == RSC_PIN_SLP) || (s_nxt.st == RSC_CYC_SLP) ||
                         (s_nxt.st == RSC_SER_SLP));
    s_nxt.payload_en = (s_nxt.st == RSC_AWAKE);
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s_r            <= '0;
      s_r.st         <= RSC_AWAKE;
      s_r.mode       <= `RSC_MODE_OFF;
      s_r.inact      <= `RSC_INACT_RST;
      s_r.fail_cnt   <= 16'h0000;
      s_r.power      <= 1'b1;
      s_r.payload_en <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign link.flow_hold_output       = s_r.flow_hold;
  assign link.power_indicator_output = s_r.power;
  assign link.rsp_valid              = s_r.rsp_valid;
  assign link.rsp_data               = s_r.rsp_data;
  assign payload_enable_o            = s_r.payload_en;
  assign rf_tx_valid_o               = s_r.tx_valid;
  assign rf_tx_data_o                = s_r.tx_data;
endmodule

// ### hw/rsc_host.sv
// Purpose: host controller end of the radio sleep link
// Assumes: APB slave on ref_clk_i, one wait state per access
// Notes:   one command outstanding at a time
`include "rsc_cfg.svh"

module rsc_host (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq_o,
  rsc_link_if.host         link
);
  import rsc_pkg::*;

  rsc_host_t s_r;
  rsc_host_t s_nxt;
  logic      acc;
  logic [`RSC_IRQ_W-1:0] ev;

  // ==========================================================
  // next state
  always_comb begin
    s_nxt           = s_r;
    s_nxt.cmd_valid = 1'b0;
    s_nxt.ser_valid = 1'b0;
    acc             = psel && penable && s_r.pready;
    s_nxt.pready    = psel && penable && !s_r.pready;
    ev              = '0;

    if (psel && penable && !s_r.pready && !pwrite) begin
      unique case (paddr)
        `RSC_A_CTRL:     s_nxt.prdata = {31'h0, s_r.sleep_req};
        `RSC_A_STATUS:   s_nxt.prdata = {s_r.rsp_data, 12'h000, link.power_indicator_output,
                                         link.flow_hold_output, s_r.ser_pend, s_r.busy};
        `RSC_A_IRQ_STAT: s_nxt.prdata = {29'h0, s_r.irq_stat};
        `RSC_A_IRQ_EN:   s_nxt.prdata = {29'h0, s_r.irq_en};
        default:         s_nxt.prdata = 32'h0000_0000;
      endcase
    end

    if (acc && pwrite) begin
      unique case (paddr)
        `RSC_A_CTRL: s_nxt.sleep_req = pwdata[0];
        `RSC_A_CMD: begin
          // a command while busy is dropped
          if (!s_r.busy) begin
            s_nxt.cmd_valid = 1'b1;
            s_nxt.busy      = 1'b1;
            s_nxt.cmd_code  = pwdata[7:0];
            s_nxt.cmd_write = pwdata[`RSC_CMD_WR_BIT];
            s_nxt.cmd_wdata = pwdata[`RSC_CMD_DATA_LSB +: 16];
          end
        end
        `RSC_A_SERIAL: begin
          if (!s_r.ser_pend) begin
            s_nxt.ser_pend = 1'b1;
            s_nxt.ser_byte = pwdata[7:0];
          end
        end
        `RSC_A_IRQ_CLR: s_nxt.irq_stat = s_r.irq_stat & ~pwdata[`RSC_IRQ_W-1:0];
        `RSC_A_IRQ_EN:  s_nxt.irq_en   = pwdata[`RSC_IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    // characters wait while the device holds flow
    if (s_r.ser_pend && !link.flow_hold_output) begin
      s_nxt.ser_valid = 1'b1;
      s_nxt.ser_data  = s_r.ser_byte;
      s_nxt.ser_pend  = 1'b0;
    end

    if (link.rsp_valid) begin
      s_nxt.busy     = 1'b0;
      s_nxt.rsp_data = link.rsp_data;
      ev[`RSC_IRQ_RSP] = 1'b1;
    end
    s_nxt.cts_q = link.flow_hold_output;
    s_nxt.pwr_q = link.power_indicator_output;
    ev[`RSC_IRQ_CTS] = s_r.cts_q && !link.flow_hold_output;
    ev[`RSC_IRQ_PWR] = !s_r.pwr_q && link.power_indicator_output;
    // set wins over a clear in the same cycle
    s_nxt.irq_stat = s_nxt.irq_stat | ev;
    s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_en);
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      s_r       <= '0;
      s_r.cts_q <= 1'b0;
      s_r.pwr_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign prdata                   = s_r.prdata;
  assign pready                   = s_r.pready;
  assign pslverr                  = 1'b0;
  assign irq_o                    = s_r.irq;
  assign link.sleep_request_input = s_r.sleep_req;
  assign link.serial_data_valid   = s_r.ser_valid;
  assign link.serial_data_input   = s_r.ser_data;
  assign link.cmd_valid           = s_r.cmd_valid;
  assign link.cmd_write           = s_r.cmd_write;
  assign link.cmd_code            = s_r.cmd_code;
  assign link.cmd_wdata           = s_r.cmd_wdata;
endmodule

// ### dv/rsc_chk.sv
// Purpose: link checks between host end and sleep controller
// Assumes: one clock, synchronous active-low reset
// Notes:   mode and inactivity mirrored from accepted writes on the link
`include "rsc_cfg.svh"

module rsc_chk (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        sleep_request_input,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        flow_hold_output,
  input  wire logic        power_indicator_output,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data
);
  // ==========================================================
  // mirror of accepted settings
  logic [3:0]  mode_r;
  logic [14:0] inact_r;
  logic        wr_mode;
  logic        wr_inact;
  assign wr_mode  = cmd_valid && cmd_write && cmd_code == `RSC_CMD_MODE &&
                    cmd_wdata <= 16'h0008 && cmd_wdata != 16'h0003;
  assign wr_inact = cmd_valid && cmd_write && cmd_code == `RSC_CMD_INACT &&
                    cmd_wdata <= `RSC_INACT_MAX;
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      mode_r  <= `RSC_MODE_OFF;
      inact_r <= `RSC_INACT_RST;
    end else begin
      if (wr_mode) begin
        mode_r <= cmd_wdata[3:0];
      end
      if (wr_inact) begin
        inact_r <= cmd_wdata[14:0];
      end
    end
  end

  // ==========================================================
  // properties
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_pin_req;
    mode_r == `RSC_MODE_PIN && sleep_request_input && !cmd_valid;
  endsequence
  sequence s_pin_rel;
    mode_r == `RSC_MODE_PIN && !sleep_request_input && !cmd_valid;
  endsequence

  a_rsp_next_cycle: assert property (cmd_valid |=> rsp_valid)
    else $error("response missing one cycle after command");
  a_rsp_single: assert property (rsp_valid && !cmd_valid |=> !rsp_valid)
    else $error("response pulse longer than one cycle");
  a_pin_sleep_out: assert property (s_pin_req |=>
                                    flow_hold_output && !power_indicator_output)
    else $error("pin sleep outputs wrong");
  a_pin_awake_out: assert property (s_pin_rel |=>
                                    !flow_hold_output && power_indicator_output)
    else $error("pin released but not awake");
  a_off_active: assert property (mode_r == `RSC_MODE_OFF |->
                                 power_indicator_output && !flow_hold_output)
    else $error("sleep disabled but outputs inactive");
  a_ser_flow_low: assert property (mode_r == `RSC_MODE_SER |-> !flow_hold_output)
    else $error("serial sleep raised flow hold");
  a_cyc_sleep_hold: assert property (mode_r >= `RSC_MODE_CYC_FIRST && !power_indicator_output
                                     |-> flow_hold_output)
    else $error("cyclic sleep without flow hold");
  a_mode_readback: assert property (cmd_valid && cmd_code == `RSC_CMD_MODE
                                    |=> rsp_data == {12'h000, mode_r})
    else $error("mode response wrong");
  a_inact_readback: assert property (cmd_valid && cmd_code == `RSC_CMD_INACT
                                     |=> rsp_data == {1'b0, inact_r})
    else $error("inactivity response wrong");
  a_temp_range: assert property (cmd_valid && cmd_code == `RSC_CMD_TEMP
                                 |=> rsp_data[15:7] == 9'h000)
    else $error("temperature above range");
endmodule

// ### dv/tb.sv
// Purpose: host end and sleep controller joined, driven over apb
// Assumes: 200 MHz clock, short unit tick
// Notes:   expectations from bench functions, lfsr seeded at 61
`include "rsc_cfg.svh"

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, irq_o, pay_en, tx_v;
  logic        rf_act = 1'b0, wi_det = 1'b0, wi_done = 1'b0, tx_fail = 1'b0;
  logic [6:0]  temp = 7'h00;
  logic [15:0] snlo = 16'h0000;
  logic [7:0]  tx_d;
  logic [15:0] lfsr = 16'h003d;
  int          miscompares = 0;
  int          checks = 0;
  int          cyc = 0;

  rsc_link_if link_if();
  rsc_dev #(.TICK_CYCLES(8)) u_rsc_dev (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .link(link_if), .rf_activity_i(rf_act), .wake_init_detect_i(wi_det),
    .wake_init_done_i(wi_done), .tx_fail_i(tx_fail), .temperature_i(temp),
    .serial_number_low_word_i(snlo), .payload_enable_o(pay_en), .rf_tx_valid_o(tx_v),
    .rf_tx_data_o(tx_d));
  rsc_host u_rsc_host (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .irq_o(irq_o), .link(link_if));
  rsc_chk u_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .sleep_request_input(link_if.sleep_request_input), .cmd_valid(link_if.cmd_valid),
    .cmd_write(link_if.cmd_write), .cmd_code(link_if.cmd_code),
    .cmd_wdata(link_if.cmd_wdata), .flow_hold_output(link_if.flow_hold_output),
    .power_indicator_output(link_if.power_indicator_output),
    .rsp_valid(link_if.rsp_valid), .rsp_data(link_if.rsp_data));

  // ==========================================================
  // clock, timeout, helpers
  always #2.5 ref_clk_i = ~ref_clk_i;

  task end_of_test();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ceiling well above the several hundred cycles the sequence needs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      end_of_test();
    end
  end

  function logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [3:0] mode_after(logic [3:0] old, logic [15:0] v);
    return (v <= 16'h0008 && v != 16'h0003) ? v[3:0] : old;
  endfunction
  function automatic logic [14:0] inact_after(logic [14:0] old, logic [15:0] v);
    return (v <= `RSC_INACT_MAX) ? v[14:0] : old;
  endfunction

  task waitc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task reset_dut();
    reset_n_i <= 1'b0;
    waitc(6);
    reset_n_i <= 1'b1;
  endtask
  // request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] q);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    // no wait-state count assumed; only the bench timeout ends a hang
    do begin
      @(posedge ref_clk_i);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
           output logic [15:0] r);
    logic [31:0] q;
    wr(`RSC_A_CMD, {d, 7'h00, w, c});
    do begin
      apb(1'b0, `RSC_A_STATUS, 32'h0, q);
    end while (q[0] !== 1'b0);
    r = q[31:16];
  endtask
  task wait_pwr(input logic v);
    int n;
    n = 0;
    while (link_if.power_indicator_output !== v && n < 400) begin
      @(posedge ref_clk_i);
      n++;
    end
    `CHK(link_if.power_indicator_output, v)
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] r, v;
    logic [3:0]  m;
    logic [14:0] in;
    logic [31:0] q;
    int          k;
    reset_dut();
    cmd(1'b0, `RSC_CMD_MODE, 16'h0, r);
    `CHK(r, 16'h0000)
    cmd(1'b0, `RSC_CMD_INACT, 16'h0, r);
    `CHK(r, 16'h0064)
    apb(1'b0, `RSC_A_STATUS, 32'h0, q);
    `CHK(q[3:2], 2'b10)
    m = 4'h0;
    for (k = 0; k < 14; k++) begin
      v = (k < 10) ? 16'(k) : rnd();
      cmd(1'b1, `RSC_CMD_MODE, v, r);
      m = mode_after(m, v);
      `CHK(r, {12'h000, m})
    end
    cmd(1'b1, `RSC_CMD_MODE, 16'h0, r);
    in = 15'h0064;
    for (k = 0; k < 6; k++) begin
      v = (k == 0) ? 16'h7fff : (k == 1) ? 16'h8000 : rnd();
      cmd(1'b1, `RSC_CMD_INACT, v, r);
      in = inact_after(in, v);
      `CHK(r, {1'b0, in})
    end
    v = rnd();
    temp <= v[6:0];
    snlo <= rnd();
    waitc(3);
    cmd(1'b0, `RSC_CMD_TEMP, 16'h0, r);
    `CHK(r, {9'h000, temp})
    cmd(1'b1, `RSC_CMD_TEMP, 16'hffff, r);
    `CHK(r, {9'h000, temp})
    cmd(1'b0, `RSC_CMD_SNLO, 16'h0, r);
    `CHK(r, snlo)
    v = rnd();
    k = 3 + int'(v[2:0]);
    repeat (k) begin
      tx_fail <= 1'b1;
      @(posedge ref_clk_i);
      tx_fail <= 1'b0;
      @(posedge ref_clk_i);
    end
    cmd(1'b0, `RSC_CMD_FAIL, 16'h0, r);
    `CHK(r, 16'(k))
    reset_dut();
    cmd(1'b0, `RSC_CMD_FAIL, 16'h0, r);
    `CHK(r, 16'h0000)
    // pin sleep, power-rise interrupt raised, cleared, then masked
    wr(`RSC_A_IRQ_EN, 32'h4);
    cmd(1'b1, `RSC_CMD_MODE, 16'h1, r);
    wr(`RSC_A_CTRL, 32'h1);
    waitc(3);
    apb(1'b0, `RSC_A_STATUS, 32'h0, q);
    `CHK(q[3:2], 2'b01)
    wr(`RSC_A_IRQ_CLR, 32'h7);
    wr(`RSC_A_CTRL, 32'h0);
    waitc(3);
    `CHK(irq_o, 1'b1)
    wr(`RSC_A_IRQ_CLR, 32'h4);
    waitc(2);
    `CHK(irq_o, 1'b0)
    wr(`RSC_A_IRQ_EN, 32'h0);
    wr(`RSC_A_CTRL, 32'h1);
    wr(`RSC_A_CTRL, 32'h0);
    waitc(3);
    apb(1'b0, `RSC_A_IRQ_STAT, 32'h0, q);
    `CHK({irq_o, q[2]}, 2'b01)
    cmd(1'b1, `RSC_CMD_MODE, 16'h0, r);
    wr(`RSC_A_CTRL, 32'h1);
    waitc(4);
    apb(1'b0, `RSC_A_STATUS, 32'h0, q);
    `CHK(q[3:2], 2'b10)
    wr(`RSC_A_CTRL, 32'h0);
    // serial sleep, woken by a character that is also forwarded
    cmd(1'b1, `RSC_CMD_INACT, 16'h1, r);
    cmd(1'b1, `RSC_CMD_MODE, 16'h2, r);
    wait_pwr(1'b0);
    wr(`RSC_A_IRQ_CLR, 32'h7);
    v = rnd();
    wr(`RSC_A_SERIAL, {24'h0, v[7:0]});
    waitc(3);
    `CHK(tx_v, 1'b1)
    waitc(1);
    `CHK(tx_d, v[7:0])
    apb(1'b0, `RSC_A_IRQ_STAT, 32'h0, q);
    `CHK(q[2], 1'b1)
    // cyclic: radio activity holds awake, listen window, initializer
    // free-running tick: awake spans must outlast one unit of phase error
    cmd(1'b1, `RSC_CMD_INACT, 16'h3, r);
    cmd(1'b1, `RSC_CMD_MODE, 16'h4, r);
    rf_act <= 1'b1;
    waitc(60);
    `CHK(link_if.power_indicator_output, 1'b1)
    rf_act <= 1'b0;
    wait_pwr(1'b0);
    `CHK(link_if.flow_hold_output, 1'b1)
    wait_pwr(1'b1);
    `CHK({link_if.flow_hold_output, pay_en}, 2'b00)
    wait_pwr(1'b0);
    wait_pwr(1'b1);
    wi_det <= 1'b1;
    @(posedge ref_clk_i);
    wi_det <= 1'b0;
    waitc(4);
    `CHK(pay_en, 1'b0)
    wi_done <= 1'b1;
    @(posedge ref_clk_i);
    wi_done <= 1'b0;
    waitc(3);
    `CHK(pay_en, 1'b1)
    wait_pwr(1'b0);
    // pin wake out of cyclic sleep
    wr(`RSC_A_CTRL, 32'h1);
    cmd(1'b1, `RSC_CMD_PWAKE, 16'h1, r);
    wait_pwr(1'b0);
    wr(`RSC_A_CTRL, 32'h0);
    waitc(3);
    `CHK(link_if.power_indicator_output, 1'b1)
    wait_pwr(1'b0);
    end_of_test();
  end
endmodule
